// ### src/sdio_clk_div.sv
`timescale 1ns/100ps
module sdio_clk_div
  import sdio_pkg::*;
#(
  parameter int HALF_BASE = SDIO_HALF_1M
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire sdio_scale_t scale,
  output logic clkOut
);

  typedef struct packed {
    logic [16:0] count;
    logic level;
  } sdio_div_state_t;

  localparam logic [16:0] BASE = 17'(HALF_BASE);

  sdio_div_state_t state;
  sdio_div_state_t next_state;
  logic [16:0] half;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    half = sdio_scale_half(BASE, scale);
    next_state = state;
    if (state.count >= half - 17'h00001) begin
      next_state.count = 17'h00000;
      next_state.level = ~state.level;
    end else begin
      next_state.count = state.count + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign clkOut = state.level;

endmodule // sdio_clk_div

// ### src/sdio_pkg.sv
package sdio_pkg;

  localparam int SDIO_CHANNELS = 32;
  localparam int SDIO_BYTE_W = 8;
  localparam int SDIO_HALF_CH = 16;
  localparam int SDIO_ADDR_W = 10;
  localparam int SDIO_SW_W = 6;
  localparam int SDIO_WIN_LSB = 3;
  localparam int SDIO_WIN_MSB = 8;
  localparam int SDIO_A9_BIT = 9;
  localparam int SDIO_OFF_W = 3;
  localparam int SDIO_DIV_W = 17;

  // port offsets inside the window
  localparam logic [2:0] SDIO_OFF_PORT0 = 3'h0;
  localparam logic [2:0] SDIO_OFF_PORT1 = 3'h1;
  localparam logic [2:0] SDIO_OFF_PORT2 = 3'h2;
  localparam logic [2:0] SDIO_OFF_PORT3 = 3'h3;

  // reset values
  localparam logic [31:0] SDIO_DO_RST = 32'h0000_0000;
  localparam logic [31:0] SDIO_DI_RST = 32'h0000_0000;
  localparam logic [7:0] SDIO_DATA_RST = 8'h00;

  // reference clock timing
  localparam longint SDIO_REF_HZ = 200_000_000;
  localparam longint SDIO_F1M_HZ = 1_000_000;
  localparam longint SDIO_F100K_HZ = 100_000;
  localparam longint SDIO_F10K_HZ = 10_000;
  localparam int SDIO_HALF_1M = int'(SDIO_REF_HZ / (2 * SDIO_F1M_HZ));
  localparam int SDIO_HALF_100K = int'(SDIO_REF_HZ / (2 * SDIO_F100K_HZ));
  localparam int SDIO_HALF_10K = int'(SDIO_REF_HZ / (2 * SDIO_F10K_HZ));

  typedef enum logic [1:0] {
    SDIO_SCALE_X1 = 2'h0,
    SDIO_SCALE_X2 = 2'h1,
    SDIO_SCALE_HALF = 2'h2,
    SDIO_SCALE_QUARTER = 2'h3
  } sdio_scale_t;

  typedef struct packed {
    logic [9:0] addr;
    logic rdN;
    logic wrN;
    logic [7:0] data;
  } sdio_bus_t;

  typedef struct packed {
    logic [31:0] di;
    logic [1:0] strobe;
    logic [5:0] sw;
    logic [1:0] jumper;
  } sdio_field_t;

  typedef struct packed {
    sdio_bus_t bus;
    sdio_field_t field;
  } sdio_async_t;

  // idle levels of every outside input: strobes and gates high
  localparam sdio_async_t SDIO_ASYNC_IDLE = '{
    bus: '{addr: 10'h000, rdN: 1'b1, wrN: 1'b1, data: 8'h00},
    field: '{di: 32'h0000_0000, strobe: 2'h3, sw: 6'h00, jumper: 2'h0}
  };

  // a bit moves only once stages two and three agree
  function automatic sdio_async_t sdio_agree(input sdio_async_t s2, input sdio_async_t s3,
                                             input sdio_async_t filt);
    logic [$bits(sdio_async_t)-1:0] diff;
    diff = s2 ^ s3;
    return (~diff & s3) | (diff & filt);
  endfunction

  function automatic logic sdio_hit(input logic [9:0] addr, input logic [5:0] sw);
    return addr[SDIO_A9_BIT] && (addr[SDIO_WIN_MSB:SDIO_WIN_LSB] == sw);
  endfunction

  function automatic logic [16:0] sdio_scale_half(input logic [16:0] base, input sdio_scale_t sc);
    case (sc)
      SDIO_SCALE_X2: return base >> 1;
      SDIO_SCALE_HALF: return base << 1;
      SDIO_SCALE_QUARTER: return base << 2;
      default: return base;
    endcase
  endfunction

endpackage

// ### src/sdio_port.sv
`timescale 1ns/100ps
module sdio_port
  import sdio_pkg::*;
#(
  parameter int HALF_1M = SDIO_HALF_1M,
  parameter int HALF_100K = SDIO_HALF_100K,
  parameter int HALF_10K = SDIO_HALF_10K
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [9:0] ioAddr,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic [7:0] ioDataIn,
  output logic [7:0] ioDataOut,
  output logic ioDataOeN,
  input wire logic [31:0] diPins,
  input wire logic [1:0] inputStrobe,
  input wire logic [5:0] base_select_switch,
  input wire logic [1:0] clock_scale_jumper,
  output logic [31:0] doPins,
  output logic [1:0] inputLatched,
  output logic refClk1M,
  output logic refClk100K,
  output logic refClk10K
);

  typedef struct packed {
    sdio_async_t s1;
    sdio_async_t s2;
    sdio_async_t s3;
    sdio_async_t filt;
    logic [1:0] strobePrev;
    logic [31:0] diHeld;
    logic [1:0] latched;
    logic pendValid;
    logic [2:0] pendOff;
    logic [7:0] pendData;
    logic [31:0] doReg;
    logic [7:0] dataOut;
    logic dataOeN;
  } sdio_port_state_t;

  sdio_port_state_t state;
  sdio_port_state_t next_state;
  sdio_async_t pinNow;
  sdio_bus_t bus;
  sdio_field_t field;
  logic [31:0] diView;
  logic [1:0] strobeFall;
  logic hit;
  logic [2:0] offset;
  logic portSel;
  logic wrActive;
  logic rdActive;
  sdio_scale_t scale;

  ////////////////////////////////////////////////////////////////////////////////
  // pin gathering
  always_comb begin
    pinNow.bus.addr = ioAddr;
    pinNow.bus.rdN = ioRdN;
    pinNow.bus.wrN = ioWrN;
    pinNow.bus.data = ioDataIn;
    pinNow.field.di = diPins;
    pinNow.field.strobe = inputStrobe;
    pinNow.field.sw = base_select_switch;
    pinNow.field.jumper = clock_scale_jumper;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the filtered bus
  always_comb begin
    bus = state.filt.bus;
    field = state.filt.field;
    hit = sdio_hit(bus.addr, field.sw);
    offset = bus.addr[SDIO_OFF_W-1:0];
    portSel = hit && (offset <= SDIO_OFF_PORT3);
    rdActive = !bus.rdN && portSel;
    wrActive = !bus.wrN && portSel;
    scale = sdio_scale_t'(field.jumper);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input view per gate half
  always_comb begin
    strobeFall = state.strobePrev & ~field.strobe;
    for (int h = 0; h < 2; h++) begin
      if (field.strobe[h]) begin
        diView[h*SDIO_HALF_CH +: SDIO_HALF_CH] = field.di[h*SDIO_HALF_CH +: SDIO_HALF_CH];
      end else begin
        diView[h*SDIO_HALF_CH +: SDIO_HALF_CH] = state.diHeld[h*SDIO_HALF_CH +: SDIO_HALF_CH];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;

    // three-stage capture of every outside level
    next_state.s1 = pinNow;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    next_state.filt = sdio_agree(state.s2, state.s3, state.filt);

    next_state.strobePrev = field.strobe;

    // transparent while high, frozen from the falling edge on
    for (int h = 0; h < 2; h++) begin
      if (field.strobe[h] || strobeFall[h]) begin
        next_state.diHeld[h*SDIO_HALF_CH +: SDIO_HALF_CH] =
          field.di[h*SDIO_HALF_CH +: SDIO_HALF_CH];
      end
      next_state.latched[h] = !field.strobe[h];
    end

    // remember write cycle contents until the strobe ends
    if (wrActive) begin
      next_state.pendValid = 1'b1;
      next_state.pendOff = offset;
      next_state.pendData = bus.data;
    end else if (bus.wrN) begin
      next_state.pendValid = 1'b0;
    end

    // commit when the write strobe is released
    if (state.pendValid && bus.wrN) begin
      case (state.pendOff)
        SDIO_OFF_PORT0: begin
          next_state.doReg[7:0] = state.pendData;
        end
        SDIO_OFF_PORT1: begin
          next_state.doReg[15:8] = state.pendData;
        end
        SDIO_OFF_PORT2: begin
          next_state.doReg[23:16] = state.pendData;
        end
        SDIO_OFF_PORT3: begin
          next_state.doReg[31:24] = state.pendData;
        end
        default: begin
          next_state.doReg = state.doReg;
        end
      endcase
    end

    // read data and bus drive
    if (rdActive) begin
      next_state.dataOeN = 1'b0;
      case (offset)
        SDIO_OFF_PORT0: begin
          next_state.dataOut = diView[7:0];
        end
        SDIO_OFF_PORT1: begin
          next_state.dataOut = diView[15:8];
        end
        SDIO_OFF_PORT2: begin
          next_state.dataOut = diView[23:16];
        end
        SDIO_OFF_PORT3: begin
          next_state.dataOut = diView[31:24];
        end
        default: begin
          next_state.dataOut = SDIO_DATA_RST;
        end
      endcase
    end else begin
      next_state.dataOeN = 1'b1;
      next_state.dataOut = SDIO_DATA_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // all stages at idle levels, so no false gate fall after reset
      state.s1 <= SDIO_ASYNC_IDLE;
      state.s2 <= SDIO_ASYNC_IDLE;
      state.s3 <= SDIO_ASYNC_IDLE;
      state.filt <= SDIO_ASYNC_IDLE;
      state.strobePrev <= 2'h3;
      state.diHeld <= SDIO_DI_RST;
      state.latched <= 2'h0;
      state.pendValid <= 1'b0;
      state.pendOff <= 3'h0;
      state.pendData <= SDIO_DATA_RST;
      state.doReg <= SDIO_DO_RST;
      state.dataOut <= SDIO_DATA_RST;
      state.dataOeN <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign doPins = state.doReg;
  assign ioDataOut = state.dataOut;
  assign ioDataOeN = state.dataOeN;
  assign inputLatched = state.latched;

  ////////////////////////////////////////////////////////////////////////////////
  // reference clock pads
  sdio_clk_div #(
    .HALF_BASE(HALF_1M)
  ) div1M (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .scale(scale),
    .clkOut(refClk1M)
  );

  sdio_clk_div #(
    .HALF_BASE(HALF_100K)
  ) div100K (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .scale(scale),
    .clkOut(refClk100K)
  );

  sdio_clk_div #(
    .HALF_BASE(HALF_10K)
  ) div10K (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .scale(scale),
    .clkOut(refClk10K)
  );

endmodule // sdio_port

// ### test/sdio_host_model.sv
`timescale 1ns/100ps
module sdio_host_model (
  input wire logic ref_clk,
  output logic [9:0] ioAddr,
  output logic ioRdN,
  output logic ioWrN,
  output logic [7:0] ioDataIn
);
  initial begin
    ioAddr = 10'h000;
    ioRdN = 1'b1;
    ioWrN = 1'b1;
    ioDataIn = 8'h00;
  end
  // one strobe at a time, fields held well past it
  task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ioAddr <= a;
    ioDataIn <= d;
    ioRdN <= wr;
    ioWrN <= ~wr;
    repeat (6) @(negedge ref_clk);
    ioRdN <= 1'b1;
    ioWrN <= 1'b1;
    repeat (8) @(negedge ref_clk);
    ioDataIn <= ~d;
  endtask
endmodule // sdio_host_model

// ### test/sdio_port_assertions.sv
`timescale 1ns/100ps
module sdio_port_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [9:0] ioAddr,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic [7:0] ioDataOut,
  input wire logic ioDataOeN,
  input wire logic [1:0] inputStrobe,
  input wire logic [5:0] base_select_switch,
  input wire logic [31:0] doPins,
  input wire logic [1:0] inputLatched,
  input wire logic refClk1M
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] rdHist;
  logic [7:0] wrHist;
  // recent strobe activity
  always_ff @(posedge ref_clk) begin
    rdHist <= {rdHist[6:0], ~ioRdN};
    wrHist <= {wrHist[6:0], ~ioWrN};
  end
  ////////////////////////////////////////
  property p_rst_state;
    disable iff (1'b0) sys_rst |=> doPins == 32'h0 && ioDataOeN && inputLatched == 2'h0;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
  property p_oe_quiet;
    ioDataOeN |-> ioDataOut == 8'h00;
  endproperty
  a_oe_quiet: assert property (p_oe_quiet) else $error("data not zero while idle");
  property p_rd_decode;
    !ioDataOeN |-> rdHist != 8'h00 && ioAddr[9] && !ioAddr[2] && ioAddr[8:3] == base_select_switch;
  endproperty
  a_rd_decode: assert property (p_rd_decode) else $error("drive outside window");
  property p_rd_release;
    ioRdN [*8] |-> ioDataOeN;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("drive after read end");
  property p_do_write;
    doPins != $past(doPins) |-> wrHist != 8'h00 && !ioAddr[2] &&
      ((doPins ^ $past(doPins)) & ~(32'hff << {ioAddr[1:0], 3'h0})) == 32'h0;
  endproperty
  a_do_write: assert property (p_do_write) else $error("output byte changed wrongly");
  property p_latch_on;
    $rose(inputLatched[0]) |-> !inputStrobe[0] && !$past(inputStrobe[0], 3);
  endproperty
  a_latch_on: assert property (p_latch_on) else $error("latch without gate fall");
  property p_latch_off;
    $fell(inputLatched[1]) |-> inputStrobe[1];
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("latch freed with gate low");
  property p_ref_clk;
    $rose(refClk1M) |-> ##[1:64] $fell(refClk1M);
  endproperty
  a_ref_clk: assert property (p_ref_clk) else $error("reference clock stuck");
  c_read: cover property (!ioDataOeN);
  c_latch: cover property ($rose(inputLatched[1]));
  c_write: cover property (doPins != $past(doPins));
endmodule // sdio_port_checker

bind sdio_port sdio_port_checker u_chk (.*);

// ### test/test_strobed_digital_io_port.sv
`timescale 1ns/100ps
module test_strobed_digital_io_port;
  logic ref_clk, sys_rst, ioRdN, ioWrN, ioDataOeN;
  logic [9:0] ioAddr;
  logic [7:0] ioDataIn, ioDataOut;
  logic [31:0] diPins, doPins, expDo, held;
  logic [1:0] inputStrobe, jumper, inputLatched;
  logic [5:0] sw;
  logic [5:0] bases [3] = '{6'h00, 6'h14, 6'h3f};
  logic [2:0] clks;
  logic [7:0] expQ [$];
  logic [31:0] rnd = 32'hb733;
  logic prevOeN = 1'b1;
  int mismatches = 0;
  int comparisons = 0;
  int drives = 0;
  int n;
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  sdio_host_model u_host (.ref_clk(ref_clk), .ioAddr(ioAddr), .ioRdN(ioRdN), .ioWrN(ioWrN), .ioDataIn(ioDataIn));
  sdio_port #(.HALF_1M(4), .HALF_100K(8), .HALF_10K(16)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ioAddr(ioAddr), .ioRdN(ioRdN), .ioWrN(ioWrN), .ioDataIn(ioDataIn), .ioDataOut(ioDataOut),
    .ioDataOeN(ioDataOeN), .diPins(diPins), .inputStrobe(inputStrobe), .base_select_switch(sw),
    .clock_scale_jumper(jumper), .doPins(doPins), .inputLatched(inputLatched), .refClk1M(clks[0]),
    .refClk100K(clks[1]), .refClk10K(clks[2]));
  ////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [9:0] at(input logic [2:0] off);
    return {1'b1, sw, off};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic hit);
    int d0;
    d0 = drives;
    if (hit) expQ.push_back(e);
    u_host.access(1'b0, a, 8'h00);
    chk("drive count", d0 + hit, drives);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d);
    chk("output pins", expDo, doPins);
  endtask
  task automatic wait_toggle(input int c);
    logic last;
    last = clks[c];
    n = 0;
    while (clks[c] === last) begin
      @(negedge ref_clk);
      n++;
      if (n == 200) begin
        mismatches++;
        wrap_up();
      end
    end
  endtask
  // first drive of each read is compared
  always @(negedge ref_clk) begin
    if (prevOeN && !ioDataOeN) begin
      drives++;
      if (expQ.size() == 0) chk("unexpected drive", 32'h1, 32'h0);
      else chk("read data", {24'h0, expQ.pop_front()}, {24'h0, ioDataOut});
    end
    prevOeN = ioDataOeN;
  end
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    diPins = 32'h0;
    inputStrobe = 2'h3;
    sw = 6'h14;
    jumper = 2'h0;
    expDo = 32'h0;
    repeat (20) @(negedge ref_clk);
    sys_rst <= 1'b0;
    chk("reset pins", 32'h0, doPins);
    foreach (bases[i]) begin
      sw <= bases[i];
      repeat (6) @(negedge ref_clk);
      for (int k = 0; k < 4; k++) begin
        rnd = xorshift(rnd);
        expDo[8*k+:8] = rnd[7:0];
        wr(at(3'(k)), rnd[7:0]);
      end
      wr({1'b1, ~bases[i], 3'h1}, 8'h5a);
      rnd = xorshift(rnd);
      diPins <= rnd;
      repeat (6) @(negedge ref_clk);
      for (int k = 0; k < 4; k++) rd(at(3'(k)), rnd[8*k+:8], 1'b1);
      rd(at(3'h4), 8'h00, 1'b0);
      rd({1'b0, sw, 3'h0}, 8'h00, 1'b0);
    end
    for (int g = 0; g < 2; g++) begin
      held = diPins;
      inputStrobe <= g ? 2'h1 : 2'h2;
      repeat (8) @(negedge ref_clk);
      chk("latched flags", g ? 32'h2 : 32'h1, {30'h0, inputLatched});
      rnd = xorshift(rnd);
      diPins <= rnd;
      repeat (6) @(negedge ref_clk);
      for (int k = 0; k < 4; k++) rd(at(3'(k)), (k / 2 == g) ? held[8*k+:8] : rnd[8*k+:8], 1'b1);
    end
    inputStrobe <= 2'h3;
    repeat (8) @(negedge ref_clk);
    chk("latched flags", 32'h0, {30'h0, inputLatched});
    for (int j = 0; j < 4; j++) begin
      jumper <= j[1:0];
      repeat (40) @(negedge ref_clk);
      for (int c = 0; c < 3; c++) begin
        wait_toggle(c);
        wait_toggle(c);
        chk("half period", (j == 1) ? (4 << c) >> 1 : (4 << c) << (j == 0 ? 0 : j - 1), n);
      end
    end
    chk("pending reads", 32'h0, expQ.size());
    wrap_up();
  end
endmodule // test_strobed_digital_io_port
